// ---- core/rtcs_regs.svh ----
// Constants for the clock chip two-wire slave port
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH

// Slave address, upper seven bits of the address byte
`define RTCS_SLAVE_ADDR 7'h68
// Last register address and last clock counter address
`define RTCS_REG_LAST 5'h13
`define RTCS_CLOCK_LAST 5'h07
// Pointer reset value
`define RTCS_PTR_RST 5'h00
// System clock rate in MHz
`define RTCS_SYS_MHZ 125
// Power-up access lockout time in microseconds
`define RTCS_LOCKOUT_US 1000
// Lockout in system clock cycles
`define RTCS_LOCKOUT_CYC (`RTCS_LOCKOUT_US * `RTCS_SYS_MHZ)

`endif

// ---- core/rtcs_pkg.sv ----
// Types for the clock chip two-wire slave port
package rtcs_pkg;

  // Link-side protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXEND = 3'b010,
    ST_ACK = 3'b011,
    ST_TX = 3'b100,
    ST_TACK = 3'b101,
    ST_TNEXT = 3'b110,
    ST_IGN = 3'b111
  } rtcs_state_t;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_WADR = 2'b01,
    KIND_DATA = 2'b10
  } rtcs_kind_t;

  // Register write carried from link to system side
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } rtcs_wr_t;

endpackage

// ---- core/rtcs_sync2.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ns
module rtcs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

// ---- core/rtcs_port.sv ----
// Two-wire slave port of the clock chip, link engine and system side
`timescale 1ns/1ns
`include "rtcs_regs.svh"

// Operation
// - Respond only after START and matching address
// - Twenty-byte space, fixed sequential order
// - Power fail aborts, clears pointer, ignores bus
// - Data changes only while clock low
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Eight data bits then ninth acknowledge
// - Unlimited bytes between START and STOP
// - Acknowledge low through acknowledge clock high
// - Master nack ends read; device releases data
// - Addressed read: write address, repeated START
// - Read sends bytes at incrementing addresses
// - Pointer advances only on acknowledge clock
// - Clock address freezes user copy update
// - Current-pointer read starts at held pointer
// - Write: first byte pointer, then data
// - Acknowledge address, word address, data bytes
// - Lockout interval after supply returns
module rtcs_port #(
  parameter int LOCKOUT_CYC = `RTCS_LOCKOUT_CYC
) (
  // System clock and reset
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  // Link sampling clock
  input wire logic LINK_CLK_I,
  // Two-wire bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Supply monitor
  input wire logic PWR_FAIL_I,
  // Register file side
  output logic [4:0] RD_ADDR_O,
  input wire logic [7:0] RD_DATA_I,
  output logic WR_EN_O,
  output logic [4:0] WR_ADDR_O,
  output logic [7:0] WR_DATA_O,
  output logic FREEZE_O
);

  // ---------------- Link domain ----------------
  logic [3:0] lsync;
  logic scl_s, sda_s, link_en, rd_ack_s;
  logic scl_q, sda_q, rd_ack_q;
  rtcs_pkg::rtcs_state_t st_reg, st_next;
  rtcs_pkg::rtcs_kind_t kind_reg, kind_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [4:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic rw_reg, rw_next;
  logic xfer_reg, xfer_next;
  logic wr_tgl_reg, wr_tgl_next;
  rtcs_pkg::rtcs_wr_t wr_hold_reg, wr_hold_next;
  logic rd_tgl_reg, rd_tgl_next;
  logic [4:0] rd_req_reg, rd_req_next;
  logic [7:0] rd_data_l_reg;
  logic [7:0] rd_hold_reg;
  logic access_ok_reg;
  logic freeze_l_reg;
  logic rd_ack_tgl_reg;

  rtcs_sync2 #(.W(4)) u_link_sync (
    .clk_i(LINK_CLK_I),
    .rst_n_i(ARST_N_I),
    .d_i({SCL_I, SDA_I, access_ok_reg, rd_ack_tgl_reg}),
    .q_o(lsync)
  );

  // Synchronised bus and crossing inputs
  assign scl_s = lsync[3];
  assign sda_s = lsync[2];
  assign link_en = lsync[1];
  assign rd_ack_s = lsync[0];

  // Bus condition decode on synchronised samples
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire addr_match = (sh_reg[7:1] == `RTCS_SLAVE_ADDR);
  wire [4:0] ptr_inc = (ptr_reg == `RTCS_REG_LAST) ? `RTCS_PTR_RST : ptr_reg + 5'h01;
  wire [4:0] wadr_load = (sh_reg[4:0] > `RTCS_REG_LAST) ? `RTCS_PTR_RST : sh_reg[4:0];
  wire freeze_l_next = xfer_reg & (ptr_reg <= `RTCS_CLOCK_LAST);

  // Protocol next-state logic
  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    xfer_next = xfer_reg;
    wr_tgl_next = wr_tgl_reg;
    wr_hold_next = wr_hold_reg;
    rd_tgl_next = rd_tgl_reg;
    rd_req_next = rd_req_reg;
    if (!link_en) begin
      // Power fail or lockout: abort, clear pointer, ignore bus
      st_next = rtcs_pkg::ST_IDLE;
      ptr_next = `RTCS_PTR_RST;
      oe_next = 1'b0;
      xfer_next = 1'b0;
    end else if (start_det) begin
      // Start or repeated start: pointer is kept
      st_next = rtcs_pkg::ST_RX;
      kind_next = rtcs_pkg::KIND_ADDR;
      cnt_next = 3'h0;
      oe_next = 1'b0;
      xfer_next = 1'b0;
    end else if (stop_det) begin
      st_next = rtcs_pkg::ST_IDLE;
      oe_next = 1'b0;
      xfer_next = 1'b0;
    end else begin
      unique case (st_reg)
        rtcs_pkg::ST_IDLE, rtcs_pkg::ST_IGN: begin
          oe_next = 1'b0;
        end
        rtcs_pkg::ST_RX: begin
          // Sample one bit per clock pulse
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              st_next = rtcs_pkg::ST_RXEND;
            end
          end
        end
        rtcs_pkg::ST_RXEND: begin
          // Byte complete: decide acknowledge on falling clock
          if (scl_fall) begin
            unique case (kind_reg)
              rtcs_pkg::KIND_ADDR: begin
                if (addr_match) begin
                  oe_next = 1'b1;
                  rw_next = sh_reg[0];
                  xfer_next = 1'b1;
                  st_next = rtcs_pkg::ST_ACK;
                  if (sh_reg[0]) begin
                    rd_tgl_next = ~rd_tgl_reg;
                    rd_req_next = ptr_reg;
                  end
                end else begin
                  st_next = rtcs_pkg::ST_IGN;
                end
              end
              rtcs_pkg::KIND_WADR: begin
                ptr_next = wadr_load;
                oe_next = 1'b1;
                st_next = rtcs_pkg::ST_ACK;
              end
              default: begin
                oe_next = 1'b1;
                st_next = rtcs_pkg::ST_ACK;
              end
            endcase
          end
        end
        rtcs_pkg::ST_ACK: begin
          // Ack held low through the whole high phase
          if (scl_rise && kind_reg == rtcs_pkg::KIND_DATA) begin
            wr_tgl_next = ~wr_tgl_reg;
            wr_hold_next = '{addr: ptr_reg, data: sh_reg};
            ptr_next = ptr_inc;
          end
          if (scl_fall) begin
            cnt_next = 3'h0;
            if (rw_reg) begin
              sh_next = rd_data_l_reg;
              oe_next = ~rd_data_l_reg[7];
              st_next = rtcs_pkg::ST_TX;
            end else begin
              oe_next = 1'b0;
              kind_next = (kind_reg == rtcs_pkg::KIND_ADDR) ?
                          rtcs_pkg::KIND_WADR : rtcs_pkg::KIND_DATA;
              st_next = rtcs_pkg::ST_RX;
            end
          end
        end
        rtcs_pkg::ST_TX: begin
          // Shift out on falling clock, release after eighth bit
          if (scl_fall) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              oe_next = 1'b0;
              st_next = rtcs_pkg::ST_TACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        rtcs_pkg::ST_TACK: begin
          // Master ack advances and fetches; nack ignores the bus until the next start
          if (scl_rise) begin
            if (!sda_s) begin
              ptr_next = ptr_inc;
              rd_tgl_next = ~rd_tgl_reg;
              rd_req_next = ptr_inc;
              st_next = rtcs_pkg::ST_TNEXT;
            end else begin
              st_next = rtcs_pkg::ST_IGN;
            end
          end
        end
        rtcs_pkg::ST_TNEXT: begin
          if (scl_fall) begin
            sh_next = rd_data_l_reg;
            oe_next = ~rd_data_l_reg[7];
            cnt_next = 3'h0;
            st_next = rtcs_pkg::ST_TX;
          end
        end
      endcase
    end
  end

  // Link state registers
  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_reg <= rtcs_pkg::ST_IDLE;
      kind_reg <= rtcs_pkg::KIND_ADDR;
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      ptr_reg <= `RTCS_PTR_RST;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      xfer_reg <= 1'b0;
      freeze_l_reg <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      st_reg <= st_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      xfer_reg <= xfer_next;
      freeze_l_reg <= freeze_l_next;
    end
  end

  // Crossing request registers and read data capture
  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_tgl_reg <= 1'b0;
      wr_hold_reg <= '0;
      rd_tgl_reg <= 1'b0;
      rd_req_reg <= `RTCS_PTR_RST;
      rd_ack_q <= 1'b0;
      rd_data_l_reg <= 8'h00;
    end else begin
      wr_tgl_reg <= wr_tgl_next;
      wr_hold_reg <= wr_hold_next;
      rd_tgl_reg <= rd_tgl_next;
      rd_req_reg <= rd_req_next;
      rd_ack_q <= rd_ack_s;
      if (rd_ack_s != rd_ack_q) begin
        rd_data_l_reg <= rd_hold_reg;
      end
    end
  end

  // Open-drain data pin: only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = oe_reg;

  // ---------------- System domain ----------------
  logic [3:0] ssync;
  logic pf_s, wr_tgl_s, rd_tgl_s;
  logic wr_tgl_q, rd_tgl_q;
  logic rd_phase_reg;
  logic [$clog2(LOCKOUT_CYC+1)-1:0] lock_cnt_reg;

  rtcs_sync2 #(.W(4)) u_sys_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(ARST_N_I),
    .d_i({PWR_FAIL_I, wr_tgl_reg, rd_tgl_reg, freeze_l_reg}),
    .q_o(ssync)
  );

  assign pf_s = ssync[3];
  assign wr_tgl_s = ssync[2];
  assign rd_tgl_s = ssync[1];

  // Toggle edges mark link requests
  wire wr_edge = wr_tgl_s ^ wr_tgl_q;
  wire rd_edge = rd_tgl_s ^ rd_tgl_q;
  wire lock_done = (lock_cnt_reg == ($clog2(LOCKOUT_CYC+1))'(LOCKOUT_CYC));

  // Supply monitor and power-up lockout
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lock_cnt_reg <= '0;
      access_ok_reg <= 1'b0;
    end else if (pf_s) begin
      lock_cnt_reg <= '0;
      access_ok_reg <= 1'b0;
    end else begin
      if (!lock_done) begin
        lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
      access_ok_reg <= lock_done;
    end
  end

  // Register write strobe toward the register file
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_tgl_q <= 1'b0;
      WR_EN_O <= 1'b0;
      WR_ADDR_O <= 5'h00;
      WR_DATA_O <= 8'h00;
    end else begin
      wr_tgl_q <= wr_tgl_s;
      WR_EN_O <= wr_edge;
      if (wr_edge) begin
        WR_ADDR_O <= wr_hold_reg.addr;
        WR_DATA_O <= wr_hold_reg.data;
      end
    end
  end

  // Read fetch: present address, take data next cycle, answer by toggle
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rd_tgl_q <= 1'b0;
      rd_phase_reg <= 1'b0;
      RD_ADDR_O <= `RTCS_PTR_RST;
      rd_hold_reg <= 8'h00;
      rd_ack_tgl_reg <= 1'b0;
    end else begin
      rd_tgl_q <= rd_tgl_s;
      rd_phase_reg <= rd_edge;
      if (rd_edge) begin
        RD_ADDR_O <= rd_req_reg;
      end
      if (rd_phase_reg) begin
        rd_hold_reg <= RD_DATA_I;
        rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
      end
    end
  end

  // User copy update freeze
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FREEZE_O <= 1'b0;
    end else begin
      FREEZE_O <= ssync[0];
    end
  end

endmodule

// ---- testbench/rtcs_port_sva.sv ----
// Assertions on the pins of the two-wire slave port
`timescale 1ns/1ns
module rtcs_port_sva #(
  parameter int LOCKOUT_CYC = 2000
) (
  // Clocks and reset
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic LINK_CLK_I,
  // Bus and supply
  input wire logic SCL_I,
  input wire logic SDA_OE_O,
  input wire logic PWR_FAIL_I,
  // Register file side
  input wire logic [4:0] RD_ADDR_O,
  input wire logic WR_EN_O,
  input wire logic [4:0] WR_ADDR_O,
  input wire logic [7:0] WR_DATA_O,
  input wire logic FREEZE_O
);
  int unsigned up_cnt_reg;
  // Cycles since reset release, saturating at the lockout
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) up_cnt_reg <= 0;
    else if (up_cnt_reg < LOCKOUT_CYC) up_cnt_reg <= up_cnt_reg + 1;
  end
  // Building blocks
  sequence s_wr;
    WR_EN_O;
  endsequence
  sequence s_pf_held;
    PWR_FAIL_I [*8];
  endsequence
  // System side
  property p_wr_pulse;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) s_wr |=> !WR_EN_O;
  endproperty
  property p_wr_hold;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      !WR_EN_O |-> $stable(WR_ADDR_O) && $stable(WR_DATA_O);
  endproperty
  property p_wr_range;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) s_wr |-> WR_ADDR_O <= 5'h13;
  endproperty
  property p_rd_range;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) RD_ADDR_O <= 5'h13;
  endproperty
  property p_freeze_wr;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) s_wr and WR_ADDR_O <= 5'h07 |-> FREEZE_O;
  endproperty
  property p_freeze_pf;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) s_pf_held |-> ##[0:40] !FREEZE_O;
  endproperty
  property p_lockout;
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I) up_cnt_reg < LOCKOUT_CYC |-> !SDA_OE_O;
  endproperty
  // Link side
  property p_oe_scl_low;
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I || PWR_FAIL_I)
      $changed(SDA_OE_O) |-> !$past(SCL_I);
  endproperty
  property p_oe_pf;
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I) s_pf_held |-> !SDA_OE_O;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write address or data moved without strobe");
  a_wr_range: assert property (p_wr_range)
    else $error("write outside register space");
  a_rd_range: assert property (p_rd_range)
    else $error("read address outside register space");
  a_freeze_wr: assert property (p_freeze_wr)
    else $error("clock address written without freeze");
  a_freeze_pf: assert property (p_freeze_pf)
    else $error("freeze held during supply fail");
  a_lockout: assert property (p_lockout)
    else $error("data line driven during lockout");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line changed while clock high");
  a_oe_pf: assert property (p_oe_pf)
    else $error("data line driven during supply fail");
endmodule
bind rtcs_port rtcs_port_sva #(.LOCKOUT_CYC(LOCKOUT_CYC)) u_sva (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .LINK_CLK_I(LINK_CLK_I), .SCL_I(SCL_I),
  .SDA_OE_O(SDA_OE_O), .PWR_FAIL_I(PWR_FAIL_I), .RD_ADDR_O(RD_ADDR_O), .WR_EN_O(WR_EN_O),
  .WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O), .FREEZE_O(FREEZE_O));

// ---- testbench/rtcs_master.sv ----
// Behavioural two-wire bus master
`timescale 1ns/1ns
module rtcs_master #(
  parameter int T = 200
) (
  // Bus pins
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // Idle bus, both lines high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Start or repeated start from a released data line
  task automatic start();
    sda_low_o = 1'b0;
    #T scl_o = 1'b1;
    #T sda_low_o = 1'b1;
    #T scl_o = 1'b0;
    #T;
  endtask
  // Stop, leaving the bus idle
  task automatic stop();
    sda_low_o = 1'b1;
    #T scl_o = 1'b1;
    #T sda_low_o = 1'b0;
    #T;
  endtask
  // One clock pulse, data set while clock low
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = !b;
    #T scl_o = 1'b1;
    #T r = sda_i;
    scl_o = 1'b0;
    #T;
  endtask
  // Byte out, MSB first, then acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Byte in, low held through acknowledge unless last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ns
module testbench;
  localparam int LOCK = 2000;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pwr_fail = 1'b0;
  logic scl;
  logic m_low;
  logic sda_oe;
  wire logic sda;
  logic [4:0] rd_addr;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic freeze;
  int fails = 0;
  int n_checks = 0;
  logic [12:0] wq[$];
  // Clocks
  always #4 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;
  // Open-drain wire with pull-up
  assign sda = !(m_low || sda_oe);
  rtcs_port #(.LOCKOUT_CYC(LOCK)) DUT (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .LINK_CLK_I(link_clk), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(), .SDA_OE_O(sda_oe), .PWR_FAIL_I(pwr_fail), .RD_ADDR_O(rd_addr),
    .RD_DATA_I({3'h5, rd_addr}), .WR_EN_O(wr_en), .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data),
    .FREEZE_O(freeze));
  rtcs_master #(.T(200)) m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  // Register file writes seen
  always @(posedge sys_clk) if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [12:0] pop();
    return wq.size() > 0 ? wq.pop_front() : 13'h1fff;
  endfunction
  // Byte out with expected acknowledge
  task automatic put(input logic [7:0] b, input logic exp);
    logic a;
    m.wr_byte(b, a);
    chk("ack", 13'(a), 13'(exp));
  endtask
  // Byte in with expected register address
  task automatic get(input logic last, input logic [4:0] a);
    logic [7:0] d;
    m.rd_byte(last, d);
    chk("read", 13'(d), 13'({3'h5, a}));
  endtask
  // Access right after reset is refused
  task automatic t_lockout();
    m.start();
    put(8'hd0, 1'b0);
    m.stop();
  endtask
  // Writes across clock range and wrap, freeze tracking
  task automatic t_write();
    m.start();
    put(8'hd0, 1'b1);
    put(8'h05, 1'b1);
    put(8'ha5, 1'b1);
    chk("freeze", 13'(freeze), 13'h1);
    put(8'h3c, 1'b1);
    put(8'h7e, 1'b1);
    chk("freeze", 13'(freeze), 13'h0);
    chk("write", pop(), {5'h05, 8'ha5});
    chk("write", pop(), {5'h06, 8'h3c});
    chk("write", pop(), {5'h07, 8'h7e});
    m.start();
    put(8'hd0, 1'b1);
    put(8'h13, 1'b1);
    put(8'h11, 1'b1);
    put(8'h22, 1'b1);
    m.stop();
    chk("freeze", 13'(freeze), 13'h0);
    chk("write", pop(), {5'h13, 8'h11});
    chk("write", pop(), {5'h00, 8'h22});
  endtask
  // Current-pointer read continues after the wrap
  task automatic t_cur();
    m.start();
    put(8'hd1, 1'b1);
    get(1'b1, 5'h01);
    m.stop();
  endtask
  // Addressed read with repeated start
  task automatic t_read();
    m.start();
    put(8'hd0, 1'b1);
    put(8'h06, 1'b1);
    m.start();
    put(8'hd1, 1'b1);
    get(1'b0, 5'h06);
    get(1'b0, 5'h07);
    get(1'b1, 5'h08);
    m.stop();
    chk("writes", 13'(wq.size()), 13'h0);
  endtask
  // Wrong address ignored until next start
  task automatic t_mismatch();
    m.start();
    put(8'ha0, 1'b0);
    put(8'hd0, 1'b0);
    m.stop();
  endtask
  // Supply fail mid-write, lockout, pointer cleared
  task automatic t_pfail();
    m.start();
    put(8'hd0, 1'b1);
    put(8'h04, 1'b1);
    @(posedge sys_clk) #1 pwr_fail = 1'b1;
    put(8'h99, 1'b0);
    m.stop();
    chk("writes", 13'(wq.size()), 13'h0);
    @(posedge sys_clk) #1 pwr_fail = 1'b0;
    m.start();
    put(8'hd0, 1'b0);
    m.stop();
    repeat (LOCK + 100) @(posedge sys_clk);
    m.start();
    put(8'hd1, 1'b1);
    get(1'b1, 5'h00);
    m.stop();
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    t_lockout();
    repeat (LOCK) @(posedge sys_clk);
    t_write();
    t_cur();
    t_read();
    t_mismatch();
    t_pfail();
    end_sim();
  end
endmodule
